// [gpc_pkg.sv]
package gpc_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [5:0]  GPC_IDX_PIN_DIR     = 6'h0b;
    localparam logic [5:0]  GPC_IDX_PIN_OUT     = 6'h0c;
    localparam logic [5:0]  GPC_IDX_SYNTH_INT   = 6'h0f;
    localparam logic [5:0]  GPC_IDX_SYNTH_NUM   = 6'h10;
    localparam logic [5:0]  GPC_IDX_AMP_LEVEL   = 6'h12;
    localparam logic [5:0]  GPC_IDX_PIN_STATUS  = 6'h30;

    localparam int          GPC_ADDR_W          = 8;
    localparam int          GPC_NPINS           = 7;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int          GPC_DIR_DRV_LSB     = 14;
    localparam int          GPC_DIR_OEN_LSB     = 7;
    localparam int          GPC_DIR_IEN_LSB     = 0;
    localparam int          GPC_OUT_UPDRV_LSB   = 14;
    localparam int          GPC_OUT_SERDRV_LSB  = 12;
    localparam int          GPC_OUT_CLKDRV_LSB  = 10;
    localparam int          GPC_OUT_IRQDRV_LSB  = 8;
    localparam int          GPC_OUT_PUP_BIT     = 7;
    localparam int          GPC_OUT_VAL_LSB     = 0;
    localparam int          GPC_AMP_PWR_C_LSB   = 6;
    localparam int          GPC_AMP_PWR_F_LSB   = 4;
    localparam int          GPC_AMP_DRV_C_LSB   = 2;
    localparam int          GPC_AMP_DRV_F_LSB   = 0;
    localparam int          GPC_STAT_OE_LSB     = 7;

    // ------------------------------------------------------------
    // reset values and writable masks
    // ------------------------------------------------------------
    localparam logic [15:0] GPC_RST_PIN_DIR     = 16'h0000;
    localparam logic [15:0] GPC_RST_PIN_OUT     = 16'h0380;
    localparam logic [15:0] GPC_RST_SYNTH_INT   = 16'h0095;
    localparam logic [15:0] GPC_RST_SYNTH_NUM   = 16'h5000;
    localparam logic [15:0] GPC_RST_AMP_LEVEL   = 16'h0000;
    localparam logic [15:0] GPC_MASK_FULL       = 16'hffff;
    localparam logic [15:0] GPC_MASK_LOW_BYTE   = 16'h00ff;
    localparam logic [1:0]  GPC_DRV_STRONGEST   = 2'h3;

endpackage : gpc_pkg

// [gpc_reg16.sv]
`timescale 1ns/10ps
// one 16-bit configuration register with byte-lane writes; bits outside
// the mask never change and read as their reset value (zero)
module gpc_reg16 #(
    parameter logic [15:0] RST  = 16'h0000,
    parameter logic [15:0] MASK = 16'hffff
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // write port
    input  wire logic        wr_en,
    input  wire logic [1:0]  be,
    input  wire logic [15:0] wdata,
    // register value
    output logic      [15:0] q
);

    logic [15:0] q_ff;
    logic [15:0] nxt_q;
    logic [15:0] lane_mask;

    // ------------------------------------------------------------
    // next value: merge enabled lanes, keep reserved bits fixed
    // ------------------------------------------------------------
    assign lane_mask = {{8{be[1]}}, {8{be[0]}}} & MASK;
    assign nxt_q     = (q_ff & ~lane_mask) | (wdata & lane_mask);

    // storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_ff <= RST;
        end else if (wr_en) begin
            q_ff <= nxt_q;
        end
    end

    assign q = q_ff;

endmodule : gpc_reg16

// [gpc_config_regs.sv]
`timescale 1ns/10ps
module gpc_config_regs
    import gpc_pkg::*;
(
    // apb clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [GPC_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // general-purpose pins
    input  wire logic [GPC_NPINS-1:0]  pin_in,
    output logic      [GPC_NPINS-1:0]  pin_out,
    output logic      [GPC_NPINS-1:0]  pin_oe,
    // pad drive controls
    output logic      [1:0]            lower_pins_drive_strength,
    output logic      [1:0]            upper_pins_drive_strength,
    output logic      [1:0]            serial_out_drive_strength,
    output logic      [1:0]            clock_out_drive_strength,
    output logic      [1:0]            irq_drive_strength,
    output logic                       irq_pullup_en,
    // synthesizer divide
    output logic      [7:0]            synth_integer_value,
    output logic      [15:0]           synth_numerator_value,
    // transmit amplifier
    output logic      [1:0]            amp_power_coarse,
    output logic      [1:0]            amp_power_fine,
    output logic      [1:0]            amp_drive_coarse,
    output logic      [1:0]            amp_drive_fine
);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic [5:0]           word_idx;
    logic                 aligned;
    logic                 hit_dir;
    logic                 hit_out;
    logic                 hit_int;
    logic                 hit_num;
    logic                 hit_amp;
    logic                 hit_stat;
    logic                 hit_any;
    logic                 setup_phase;
    logic                 access_wr;
    logic [1:0]           wr_be;

    // decode is word based; byte offsets inside a word are unmapped
    assign word_idx    = paddr[GPC_ADDR_W-1:2];
    assign aligned     = (paddr[1:0] == 2'h0);
    assign hit_dir     = aligned && (word_idx == GPC_IDX_PIN_DIR);
    assign hit_out     = aligned && (word_idx == GPC_IDX_PIN_OUT);
    assign hit_int     = aligned && (word_idx == GPC_IDX_SYNTH_INT);
    assign hit_num     = aligned && (word_idx == GPC_IDX_SYNTH_NUM);
    assign hit_amp     = aligned && (word_idx == GPC_IDX_AMP_LEVEL);
    assign hit_stat    = aligned && (word_idx == GPC_IDX_PIN_STATUS);
    assign hit_any     = hit_dir | hit_out | hit_int | hit_num | hit_amp | hit_stat;
    assign setup_phase = psel && !penable;
    // zero wait states: a write lands on the first access edge
    assign access_wr   = psel && penable && pwrite && hit_any;
    assign wr_be       = pstrb[1:0];

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    logic [15:0]          dir_q;
    logic [15:0]          out_q;
    logic [15:0]          int_q;
    logic [15:0]          num_q;
    logic [15:0]          amp_q;

    // pin direction: all enables clear after reset, so pins are inputs
    gpc_reg16 #(.RST(GPC_RST_PIN_DIR), .MASK(GPC_MASK_FULL)) u_dir (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (access_wr && hit_dir),
        .be      (wr_be),
        .wdata   (pwdata[15:0]),
        .q       (dir_q)
    );

    // pin values, drive strengths and pullup; irq drive and pullup reset set
    gpc_reg16 #(.RST(GPC_RST_PIN_OUT), .MASK(GPC_MASK_FULL)) u_out (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (access_wr && hit_out),
        .be      (wr_be),
        .wdata   (pwdata[15:0]),
        .q       (out_q)
    );

    // integer divide, upper byte reserved
    gpc_reg16 #(.RST(GPC_RST_SYNTH_INT), .MASK(GPC_MASK_LOW_BYTE)) u_int (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (access_wr && hit_int),
        .be      (wr_be),
        .wdata   (pwdata[15:0]),
        .q       (int_q)
    );

    // fractional numerator, all sixteen bits writable
    gpc_reg16 #(.RST(GPC_RST_SYNTH_NUM), .MASK(GPC_MASK_FULL)) u_num (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (access_wr && hit_num),
        .be      (wr_be),
        .wdata   (pwdata[15:0]),
        .q       (num_q)
    );

    // amplifier levels, upper byte reserved
    gpc_reg16 #(.RST(GPC_RST_AMP_LEVEL), .MASK(GPC_MASK_LOW_BYTE)) u_amp (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (access_wr && hit_amp),
        .be      (wr_be),
        .wdata   (pwdata[15:0]),
        .q       (amp_q)
    );

    // ------------------------------------------------------------
    // pin control
    // ------------------------------------------------------------
    logic [GPC_NPINS-1:0] pin_output_enable;
    logic [GPC_NPINS-1:0] pin_input_enable;
    logic [GPC_NPINS-1:0] pin_output_value;

    assign pin_output_enable = dir_q[GPC_DIR_OEN_LSB +: GPC_NPINS];
    assign pin_input_enable  = dir_q[GPC_DIR_IEN_LSB +: GPC_NPINS];
    assign pin_output_value  = out_q[GPC_OUT_VAL_LSB +: GPC_NPINS];
    // input enable wins when both are set
    assign pin_oe  = pin_output_enable & ~pin_input_enable;
    // value only reaches a pin that drives; others show low on the output
    assign pin_out = pin_output_value & pin_oe;

    // ------------------------------------------------------------
    // field outputs
    // ------------------------------------------------------------
    assign lower_pins_drive_strength = dir_q[GPC_DIR_DRV_LSB +: 2];
    assign upper_pins_drive_strength = out_q[GPC_OUT_UPDRV_LSB +: 2];
    assign serial_out_drive_strength = out_q[GPC_OUT_SERDRV_LSB +: 2];
    assign clock_out_drive_strength  = out_q[GPC_OUT_CLKDRV_LSB +: 2];
    assign irq_drive_strength        = out_q[GPC_OUT_IRQDRV_LSB +: 2];
    assign irq_pullup_en             = out_q[GPC_OUT_PUP_BIT];
    assign synth_integer_value       = int_q[7:0];
    assign synth_numerator_value     = num_q;
    assign amp_power_coarse          = amp_q[GPC_AMP_PWR_C_LSB +: 2];
    assign amp_power_fine            = amp_q[GPC_AMP_PWR_F_LSB +: 2];
    // drive fields are stored as written; software is expected to leave them
    assign amp_drive_coarse          = amp_q[GPC_AMP_DRV_C_LSB +: 2];
    assign amp_drive_fine            = amp_q[GPC_AMP_DRV_F_LSB +: 2];

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [15:0]          stat_word;
    logic [15:0]          rd_word;
    logic [31:0]          prdata_ff;
    logic                 pslverr_ff;

    // status shows sampled pin levels and the resolved direction
    assign stat_word = {2'h0, pin_oe, pin_in};
    assign rd_word   = ({16{hit_dir}}  & dir_q)
                     | ({16{hit_out}}  & out_q)
                     | ({16{hit_int}}  & int_q)
                     | ({16{hit_num}}  & num_q)
                     | ({16{hit_amp}}  & amp_q)
                     | ({16{hit_stat}} & stat_word);

    // captured in the setup cycle so data comes from flops in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (setup_phase) begin
            prdata_ff  <= {16'h0000, rd_word};
            pslverr_ff <= !hit_any;
        end
    end

    assign pready  = 1'b1;
    assign prdata  = (psel && penable && !pwrite) ? prdata_ff : 32'h0000_0000;
    assign pslverr = psel && penable && pslverr_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup_read(logic hit);
        psel && !penable && !pwrite && hit;
    endsequence

    sequence s_write_low(logic hit);
        access_wr && hit && pstrb[0];
    endsequence

    sequence s_write_high(logic hit);
        access_wr && hit && pstrb[1];
    endsequence

    property p_pin_drive;
        s_write_low(hit_out) |=> ((pin_out ^ $past(pwdata[6:0])) & pin_oe) == 7'h00;
    endproperty
    a_pin_drive: assert property (p_pin_drive)
        else $error("driving pin does not follow written value");

    // checked against the written enables, so a broken resolve would show
    property p_input_wins;
        s_write_low(hit_dir) ##0 pstrb[1] |=>
            pin_oe == ($past(pwdata[13:7]) & ~$past(pwdata[6:0]));
    endproperty
    a_input_wins: assert property (p_input_wins)
        else $error("pin drives while input enabled or not an output");

    property p_reset_inputs;
        $past(!presetn) |-> (pin_oe == 7'h00) && (irq_drive_strength == GPC_DRV_STRONGEST)
                            && irq_pullup_en && (upper_pins_drive_strength == 2'h0);
    endproperty
    a_reset_inputs: assert property (p_reset_inputs)
        else $error("wrong pin or drive state after reset");

    property p_upper_drive;
        s_write_high(hit_out) |=> upper_pins_drive_strength == $past(pwdata[15:14]);
    endproperty
    a_upper_drive: assert property (p_upper_drive)
        else $error("upper pin drive not updated");

    property p_ser_clk_drive;
        s_write_high(hit_out) |=> (serial_out_drive_strength == $past(pwdata[13:12]))
                                  && (clock_out_drive_strength == $past(pwdata[11:10]));
    endproperty
    a_ser_clk_drive: assert property (p_ser_clk_drive)
        else $error("serial or clock drive not updated");

    property p_pullup;
        s_write_low(hit_out) |=> irq_pullup_en == $past(pwdata[7]);
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("pullup enable not updated");

    property p_int_reserved;
        s_setup_read(hit_int) ##1 penable |-> (prdata[31:8] == 24'h00_0000)
                                              && (prdata[7:0] == synth_integer_value);
    endproperty
    a_int_reserved: assert property (p_int_reserved)
        else $error("integer divide readback wrong");

    property p_num_write;
        s_write_low(hit_num) ##0 pstrb[1] |=> synth_numerator_value == $past(pwdata[15:0]);
    endproperty
    a_num_write: assert property (p_num_write)
        else $error("numerator not updated");

    property p_amp_write;
        s_write_low(hit_amp) |=> (amp_power_coarse == $past(pwdata[7:6]))
                                 && (amp_power_fine == $past(pwdata[5:4]));
    endproperty
    a_amp_write: assert property (p_amp_write)
        else $error("amplifier power fields not updated");

    property p_num_hold;
        !(access_wr && hit_num) |=> $stable(synth_numerator_value);
    endproperty
    a_num_hold: assert property (p_num_hold)
        else $error("numerator changed without a write");

    property p_readback;
        s_setup_read(hit_num) ##1 (psel && penable) |-> prdata[15:0] == synth_numerator_value;
    endproperty
    a_readback: assert property (p_readback)
        else $error("numerator readback wrong");

    property p_unmapped_err;
        (psel && !penable && !hit_any) ##1 penable |-> pslverr && (prdata == 32'h0000_0000);
    endproperty
    a_unmapped_err: assert property (p_unmapped_err)
        else $error("unmapped access not refused");

    property p_amp_reserved;
        s_setup_read(hit_amp) ##1 penable |-> (prdata[31:8] == 24'h00_0000)
            && (prdata[7:0] == {amp_power_coarse, amp_power_fine, amp_drive_coarse, amp_drive_fine});
    endproperty
    a_amp_reserved: assert property (p_amp_reserved)
        else $error("amplifier readback wrong");

    property p_stat_read;
        s_setup_read(hit_stat) ##1 penable |-> (prdata[13:7] == pin_oe)
                                               && (prdata[31:14] == 18'h0_0000);
    endproperty
    a_stat_read: assert property (p_stat_read)
        else $error("status does not show resolved direction");

endmodule : gpc_config_regs

// [gpc_tb.sv]
`timescale 1ns/10ps
module testbench
    import gpc_pkg::*;
();

    // ------------------------------------------------------------
    // signals and design under test
    // ------------------------------------------------------------
    logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [GPC_ADDR_W-1:0] paddr;
    logic [31:0]           pwdata, prdata;
    logic [3:0]            pstrb;
    logic [GPC_NPINS-1:0]  pin_in, pin_out, pin_oe;
    logic [1:0]            lo_drv, up_drv, ser_drv, clk_drv, irq_drv;
    logic [1:0]            pwr_c, pwr_f, drv_c, drv_f;
    logic                  pup;
    logic [7:0]            s_int;
    logic [15:0]           s_num;
    int                    errors, total_checks;

    // byte address is four times the register index
    localparam logic [7:0] A_DIR  = {GPC_IDX_PIN_DIR, 2'b00};
    localparam logic [7:0] A_OUT  = {GPC_IDX_PIN_OUT, 2'b00};
    localparam logic [7:0] A_INT  = {GPC_IDX_SYNTH_INT, 2'b00};
    localparam logic [7:0] A_NUM  = {GPC_IDX_SYNTH_NUM, 2'b00};
    localparam logic [7:0] A_AMP  = {GPC_IDX_AMP_LEVEL, 2'b00};
    localparam logic [7:0] A_STAT = {GPC_IDX_PIN_STATUS, 2'b00};

    gpc_config_regs DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .lower_pins_drive_strength(lo_drv), .upper_pins_drive_strength(up_drv),
        .serial_out_drive_strength(ser_drv), .clock_out_drive_strength(clk_drv),
        .irq_drive_strength(irq_drv), .irq_pullup_en(pup),
        .synth_integer_value(s_int), .synth_numerator_value(s_num),
        .amp_power_coarse(pwr_c), .amp_power_fine(pwr_f),
        .amp_drive_coarse(drv_c), .amp_drive_fine(drv_f)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task wrap_up;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            errors++;
        end
    endtask : chk

    // one apb transfer; the wait for pready is bounded so a hang ends the run
    task apb(input logic [7:0] a, input logic w, input logic [15:0] d,
             input logic [3:0] s, output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {16'h0000, d};
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            errors++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b1, d, 4'h3, r, e);
    endtask : wr

    task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b0, 16'h0000, 4'h0, r, e);
        chk(r, exp);
        chk(32'(e), 32'(exp_err));
    endtask : rd_chk

    // let the write edge's register updates land before looking at outputs
    task settle;
        @(negedge pclk);
    endtask : settle

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_reset;
        settle();
        chk(32'(pin_oe), 32'h0000_0000);
        chk(32'(pin_out), 32'h0000_0000);
        chk(32'({up_drv, ser_drv, clk_drv}), 32'h0000_0000);
        chk(32'(irq_drv), 32'h0000_0003);
        chk(32'(pup), 32'h0000_0001);
        chk(32'({s_int, s_num}), 32'h0095_5000);
        rd_chk(A_OUT, 32'h0000_0380, 1'b0);
        rd_chk(A_DIR, 32'h0000_0000, 1'b0);
        rd_chk(A_INT, 32'h0000_0095, 1'b0);
        rd_chk(A_NUM, 32'h0000_5000, 1'b0);
        rd_chk(A_AMP, 32'h0000_0000, 1'b0);
        $display("test reset done");
    endtask : t_reset

    task t_pins;
        logic [6:0]  oen, ien, oe;
        logic [31:0] r;
        logic        e;
        oen = 7'h5b;
        ien = 7'h16;
        oe = oen & ~ien;
        pin_in <= 7'h35;
        wr(A_DIR, {2'b10, oen, ien});
        wr(A_OUT, 16'h037f);
        settle();
        chk(32'(pin_oe), 32'(oe));
        chk(32'(pin_out), 32'(7'h7f & oe));
        chk(32'(lo_drv), 32'h0000_0002);
        wr(A_OUT, 16'h032a);
        settle();
        chk(32'(pin_out), 32'(7'h2a & oe));
        // status is read only: a write there is dropped without error
        apb(A_STAT, 1'b1, 16'hffff, 4'h3, r, e);
        chk(32'(e), 32'h0000_0000);
        rd_chk(A_STAT, 32'({oe, 7'h35}), 1'b0);
        wr(A_DIR, 16'h0000);
        settle();
        chk(32'({pin_oe, pin_out}), 32'h0000_0000);
        $display("test pins done");
    endtask : t_pins

    task t_drive;
        logic [31:0] r;
        logic        e;
        wr(A_OUT, 16'hb400);
        settle();
        chk(32'(up_drv), 32'h0000_0002);
        chk(32'({ser_drv, clk_drv}), 32'h0000_000d);
        chk(32'(irq_drv), 32'h0000_0000);
        chk(32'(pup), 32'h0000_0000);
        // low byte lane only: the drive fields above must survive
        apb(A_OUT, 1'b1, 16'hffff, 4'h1, r, e);
        rd_chk(A_OUT, 32'h0000_b4ff, 1'b0);
        chk(32'(pup), 32'h0000_0001);
        $display("test drive done");
    endtask : t_drive

    task t_channel;
        logic [23:0] tot;
        for (int i = 0; i < 16; i++) begin
            tot = 24'h95_5000 + 24'(i) * 24'h00_5000;
            wr(A_INT, {8'hff, tot[23:16]});
            wr(A_NUM, tot[15:0]);
            settle();
            chk(32'(s_int), 32'(tot[23:16]));
            chk(32'(s_num), 32'(tot[15:0]));
        end
        rd_chk(A_INT, 32'h0000_009a, 1'b0);
        rd_chk(A_NUM, 32'h0000_0000, 1'b0);
        $display("test channel done");
    endtask : t_channel

    task t_amp;
        wr(A_AMP, 16'hfff0);
        settle();
        chk(32'({pwr_c, pwr_f, drv_c, drv_f}), 32'h0000_00f0);
        rd_chk(A_AMP, 32'h0000_00f0, 1'b0);
        wr(A_AMP, 16'h0090);
        settle();
        chk(32'({pwr_c, pwr_f}), 32'h0000_0009);
        $display("test amplifier done");
    endtask : t_amp

    task t_bad;
        logic [31:0] r;
        logic        e;
        apb(8'h44, 1'b1, 16'h1234, 4'h3, r, e);
        chk(32'(e), 32'h0000_0001);
        rd_chk(8'h49, 32'h0000_0000, 1'b1);
        rd_chk(A_AMP, 32'h0000_0090, 1'b0);
        $display("test unmapped done");
    endtask : t_bad

    // ------------------------------------------------------------
    // clock and main sequence
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        pin_in = 7'h00;
        errors = 0;
        total_checks = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_pins();
        t_drive();
        t_channel();
        t_amp();
        t_bad();
        // a second reset in mid-run must restore every default
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        wrap_up();
    end

endmodule : testbench
